// [hdl/xmb_pkg.sv]
// Constants, register map and state type of the external memory bus cycle block
package xmb_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int HALF_PHASE_NS  = 40;
  localparam int HALF_PHASE_CYC = (HALF_PHASE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int DIV_W          = 4;
  localparam int STRAP_SETTLE   = 3;
  localparam int ADDR_W         = 22;
  localparam int BLOCK_SEL_BIT  = 21;
  localparam int BYTE_W         = 8;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int CTRL_W       = 7;
  localparam int CTRL_FLOAT   = 0;
  localparam int CTRL_BUS_REQUEST_N_EN = 1;
  localparam int CTRL_LSE     = 2;
  localparam int CTRL_DS2_AF  = 3;
  localparam int CTRL_RW_AF   = 4;
  localparam int CTRL_EXT     = 5;
  localparam int CTRL_WAIT    = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  localparam int CMD_WRITE    = 0;
  localparam int CMD_INTERNAL = 1;

  localparam int STAT_BUSY   = 0;
  localparam int STAT_HOLD   = 1;
  localparam int STAT_STRAP  = 2;
  localparam int STAT_RD_LSB = 8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_T1_LO, ST_T1_HI, ST_WAIT, ST_T2_LO, ST_HOLD, ST_T2_HI
  } xmb_state_e;
endpackage : xmb_pkg

// [hdl/xmb_sync.sv]
// Two-flop synchroniser for pin inputs
module xmb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // xmb_sync

// [hdl/xmb_phase_div.sv]
// Divider giving one enable pulse per half phase of the memory cycle
module xmb_phase_div
  import xmb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam logic [DIV_W-1:0] LAST = DIV_W'(HALF_PHASE_CYC - 1);
  logic [DIV_W-1:0] cnt_q;
  wire              wrap = (cnt_q == LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick  <= wrap;
    end
  end
endmodule // xmb_phase_div

// [hdl/xmb_core.sv]
// External memory bus cycle generator with AHB-Lite register access
module xmb_core
  import xmb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        romless_strap,
  input  wire logic        bus_request_n,
  input  wire logic [7:0]  ad_lo_in,
  output logic [7:0]       ad_lo_out,
  output logic             ad_lo_oe,
  output logic [7:0]       addr_hi_out,
  output logic             addr_hi_oe,
  output logic             addr_strobe_n,
  output logic             addr_strobe_oe,
  output logic             data_strobe_n,
  output logic             data_strobe_oe,
  output logic             lower_block_strobe_n,
  output logic             lower_block_strobe_oe,
  output logic             rw_out,
  output logic             rw_oe,
  output logic             bus_ack_n
);
  xmb_state_e         st_q, st_d;
  logic [CTRL_W-1:0]  ctrl_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [BYTE_W-1:0]  wdata_q, rdata_q;
  logic               pend_q, wr_q, int_q, cwr_q, cint_q, drv_lo_q;
  logic               ap_valid_q, ap_write_q, strap_q, strap_done_q;
  logic [7:0]         ap_addr_q;
  logic [1:0]         settle_q;
  logic               ph_en, bus_request_n_s, strap_s;
  logic [7:0]         ad_lo_s;

  xmb_phase_div u_div (
    .clk   (hclk),
    .rst_n (hresetn),
    .tick  (ph_en)
  );

  xmb_sync #(.WIDTH(10), .RST_VAL(10'h3ff)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({bus_request_n, romless_strap, ad_lo_in}),
    .q     ({bus_request_n_s, strap_s, ad_lo_s})
  );

  // Bus decode
  wire ap_take = hsel & htrans[1] & hready;
  wire wr_en   = ap_valid_q & ap_write_q;
  wire wr_ctrl = wr_en & (ap_addr_q == OFS_CTRL);
  wire wr_addr = wr_en & (ap_addr_q == OFS_ADDR);
  wire wr_wdat = wr_en & (ap_addr_q == OFS_WDATA);
  wire wr_cmd  = wr_en & (ap_addr_q == OFS_CMD);
  wire busy    = pend_q | (st_q != ST_IDLE);
  wire hold    = (st_q == ST_HOLD);
  wire [31:0] status_w = {16'h0000, rdata_q, 5'h00, strap_q, hold, busy};
  wire [7:0]  rd_ofs   = haddr[7:0];
  wire [31:0] rd_mux   =
    (rd_ofs == OFS_CTRL)   ? {25'h0000000, ctrl_q} :
    (rd_ofs == OFS_ADDR)   ? {10'h000, addr_q} :
    (rd_ofs == OFS_WDATA)  ? {24'h000000, wdata_q} :
    (rd_ofs == OFS_STATUS) ? status_w : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      ap_valid_q <= ap_take;
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr[7:0];
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (ap_take && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // Strap caught once the synchroniser has settled after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q     <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q      <= 1'b0;
    end else if (!strap_done_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == 2'(STRAP_SETTLE - 1)) begin
        strap_done_q <= 1'b1;
        strap_q      <= strap_s;
      end
    end
  end

  // Software settings; unless CTRL is written in the same cycle, the strap sets external mode with wait cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= CTRL_RST;
      addr_q  <= '0;
      wdata_q <= 8'h00;
    end else begin
      if (wr_ctrl)
        ctrl_q <= hwdata[CTRL_W-1:0];
      else if (!strap_done_q && settle_q == 2'(STRAP_SETTLE - 1) && strap_s)
        ctrl_q <= ctrl_q | CTRL_W'((1 << CTRL_EXT) | (1 << CTRL_WAIT));
      if (wr_addr)
        addr_q <= hwdata[ADDR_W-1:0];
      if (wr_wdat)
        wdata_q <= hwdata[BYTE_W-1:0];
    end
  end

  // Command taken only while idle; a busy write is dropped
  wire launch = (st_q == ST_IDLE) & pend_q & ph_en;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      cwr_q  <= 1'b0;
      cint_q <= 1'b0;
    end else if (wr_cmd && !busy) begin
      pend_q <= 1'b1;
      cwr_q  <= hwdata[CMD_WRITE];
      cint_q <= hwdata[CMD_INTERNAL];
    end else if (launch) begin
      pend_q <= 1'b0;
    end
  end

  wire bus_request_n_on = ctrl_q[CTRL_BUS_REQUEST_N_EN] & ~bus_request_n_s;
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (launch) st_d = ST_T1_LO;
      ST_T1_LO: if (ph_en) st_d = ST_T1_HI;
      ST_T1_HI: if (ph_en) st_d = ctrl_q[CTRL_WAIT] ? ST_WAIT : ST_T2_LO;
      ST_WAIT:  if (ph_en) st_d = ST_T2_LO;
      ST_T2_LO: if (ph_en) st_d = bus_request_n_on ? ST_HOLD : ST_T2_HI;
      ST_HOLD:  if (ph_en && !bus_request_n_on) st_d = ST_T2_LO;
      ST_T2_HI: if (ph_en) st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  wire t1_start  = (st_d == ST_T1_LO) & (st_q != ST_T1_LO);
  wire t2_start  = (st_d == ST_T2_LO) & (st_q != ST_T2_LO);
  wire ext_d     = t1_start ? ~cint_q : ~int_q;
  wire upper_d   = t1_start ? addr_q[BLOCK_SEL_BIT] : 1'b0;
  wire hold_d    = (st_d == ST_HOLD);
  wire port_en   = ctrl_q[CTRL_EXT] & ~hold_d;
  wire strb_en   = port_en & ~ctrl_q[CTRL_FLOAT];
  wire rd_catch  = (st_q == ST_T2_LO) & (st_d == ST_T2_HI) & ~wr_q & ~int_q;

  logic sel_upper_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      int_q       <= 1'b0;
      sel_upper_q <= 1'b0;
    end else if (t1_start) begin
      wr_q        <= cwr_q;
      int_q       <= cint_q;
      sel_upper_q <= upper_d;
    end
  end

  // Strobe decode for the coming state
  wire as_d   = ~((st_d == ST_T1_LO) & ext_d);
  wire ds_on  = (st_d == ST_T2_LO) & ~int_q;
  wire up_d   = sel_upper_q | ~ctrl_q[CTRL_LSE];
  wire ds_d   = ~(ds_on & up_d);
  wire ds2_d  = ~(ds_on & ~up_d);
  wire rw_d   = t1_start ? ~cwr_q : rw_out;
  // Low port: address in T1, then write data held or floated for reads
  wire drv_lo_d = (t1_start & ~cint_q) ? 1'b1 :
                  (t2_start & ~wr_q & ~int_q) ? 1'b0 : drv_lo_q;
  wire [7:0] lo_d = (t1_start & ~cint_q) ? addr_q[7:0] :
                    (t2_start & wr_q & ~int_q) ? wdata_q : ad_lo_out;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_strobe_n         <= 1'b1;
      data_strobe_n         <= 1'b1;
      lower_block_strobe_n  <= 1'b1;
      rw_out                <= 1'b1;
      addr_strobe_oe        <= 1'b0;
      data_strobe_oe        <= 1'b0;
      lower_block_strobe_oe <= 1'b0;
      rw_oe                 <= 1'b0;
      ad_lo_out             <= 8'h00;
      ad_lo_oe              <= 1'b0;
      addr_hi_out           <= 8'h00;
      addr_hi_oe            <= 1'b0;
      drv_lo_q              <= 1'b0;
      bus_ack_n             <= 1'b1;
      rdata_q               <= 8'h00;
      st_q                  <= ST_IDLE;
    end else begin
      st_q                  <= st_d;
      addr_strobe_n         <= as_d;
      data_strobe_n         <= ds_d;
      lower_block_strobe_n  <= ds2_d;
      rw_out                <= rw_d;
      addr_strobe_oe        <= strb_en;
      data_strobe_oe        <= strb_en;
      lower_block_strobe_oe <= strb_en & ctrl_q[CTRL_DS2_AF];
      rw_oe                 <= strb_en & ctrl_q[CTRL_RW_AF];
      drv_lo_q              <= drv_lo_d;
      ad_lo_out             <= lo_d;
      ad_lo_oe              <= port_en & drv_lo_d;
      addr_hi_oe            <= port_en;
      bus_ack_n             <= ~hold_d;
      if (t1_start && !cint_q)
        addr_hi_out <= addr_q[15:8];
      if (rd_catch)
        rdata_q <= ad_lo_s;
    end
  end

  // Checks
  as_in_t1_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !addr_strobe_n |-> st_q == ST_T1_LO && !int_q)
    else $error("address strobe low outside address phase");
  ds_ext_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !data_strobe_n |-> st_q == ST_T2_LO && !int_q)
    else $error("data strobe low outside external data phase");
  ds2_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !lower_block_strobe_n |-> !sel_upper_q && data_strobe_n)
    else $error("lower strobe with upper block selected");
  ds2_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(ctrl_q[CTRL_LSE]) |-> lower_block_strobe_n)
    else $error("lower strobe active while disabled");
  rd_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_T2_LO && !wr_q && !int_q) |-> !ad_lo_oe)
    else $error("low port driven during read data phase");
  wr_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_T2_LO && wr_q && !int_q) |-> ad_lo_out == wdata_q
      ##1 ad_lo_out == wdata_q)
    else $error("write data not on low port");
  float_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(ctrl_q[CTRL_FLOAT]) |-> !addr_strobe_oe && !data_strobe_oe && !rw_oe)
    else $error("strobes driven while float bit set");
  two_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(st_q == ST_T1_LO) && !ctrl_q[CTRL_WAIT] && !ctrl_q[CTRL_BUS_REQUEST_N_EN])
      |-> ##[13:16] st_q == ST_IDLE)
    else $error("cycle not four half phases long");
  rw_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(rw_out) |-> st_q == ST_T1_LO && rw_out == !wr_q)
    else $error("read/write changed mid cycle");
  addr_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(addr_hi_out) |-> st_q == ST_T1_LO)
    else $error("high address changed outside address phase");
  ds2_af_a: assert property (@(posedge hclk) disable iff (!hresetn)
    lower_block_strobe_oe |-> $past(ctrl_q[CTRL_DS2_AF]))
    else $error("lower strobe driven without port enable");
  hold_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hold |-> !ad_lo_oe && !addr_hi_oe && !addr_strobe_oe && !bus_ack_n)
    else $error("bus driven during hold");
  idle_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == ST_IDLE |-> addr_strobe_n && data_strobe_n
      && lower_block_strobe_n)
    else $error("strobe active while idle");

  ext_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_catch);
  ext_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
    st_q == ST_T2_LO && wr_q && !int_q);
  hold_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(hold));
  lower_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !lower_block_strobe_n);
endmodule // xmb_core

// [tb/xmb_mem_model.sv]
// Behavioural external memory seen through the resolved bus wires
module xmb_mem_model (
  input  wire logic        hclk,
  input  wire logic        as_w,
  input  wire logic        ds_w,
  input  wire logic        ds2_w,
  input  wire logic        rw_w,
  input  wire logic [7:0]  ad_w,
  input  wire logic [7:0]  hi_w,
  output logic      [7:0]  ad_drv,
  output logic      [15:0] last_addr,
  output logic             last_rw,
  output int               as_cnt,
  output int               ds_cnt,
  output int               ds2_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];
  logic [7:0] idle_pat = 8'h5a;
  initial begin
    as_cnt = 0;
    ds_cnt = 0;
    ds2_cnt = 0;
  end
  // Released bus must not look like held data
  always @(posedge hclk) idle_pat <= ~idle_pat;
  always @(posedge as_w) begin
    last_addr = {hi_w, ad_w};
    last_rw = rw_w;
    as_cnt++;
  end
  always @* begin
    if (!ds_w && rw_w) ad_drv = mem[{1'b1, last_addr[7:0]}];
    else if (!ds2_w && rw_w) ad_drv = mem[{1'b0, last_addr[7:0]}];
    else ad_drv = idle_pat;
  end
  always @(posedge ds_w) begin
    if (rw_w === 1'b0) mem[{1'b1, last_addr[7:0]}] = ad_w;
    ds_cnt++;
  end
  always @(posedge ds2_w) begin
    if (rw_w === 1'b0) mem[{1'b0, last_addr[7:0]}] = ad_w;
    ds2_cnt++;
  end
endmodule // xmb_mem_model

// [tb/xmb_core_tb_top.sv]
// Self-checking bench for the external memory bus cycle block
module xmb_core_tb_top import xmb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h38;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        bus_request_n = 1'b1, hreadyout, hresp, last_rw;
  logic        romless_strap = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [7:0]  ad_lo_out, addr_hi_out, ad_drv, ad_w, hi_w;
  logic        ad_lo_oe, addr_hi_oe, as_n, as_oe, ds_n, ds_oe, ds2_n, ds2_oe;
  logic        rw_out, rw_oe, bus_ack_n, as_w, ds_w, ds2_w, rw_w, lse;
  logic [15:0] last_addr;
  int          as_cnt, ds_cnt, ds2_cnt, cyc = 0;
  int          fail_count = 0, samples_checked = 0;

  assign as_w  = as_oe === 1'b1 ? as_n : 1'b1;
  assign ds_w  = ds_oe === 1'b1 ? ds_n : 1'b1;
  assign ds2_w = ds2_oe === 1'b1 ? ds2_n : 1'b1;
  assign rw_w  = rw_oe === 1'b1 ? rw_out : 1'b1;
  assign ad_w  = ad_lo_oe === 1'b1 ? ad_lo_out : ad_drv;
  assign hi_w  = addr_hi_oe === 1'b1 ? addr_hi_out : ~addr_hi_out;

  xmb_core i_xmb_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .romless_strap(romless_strap),
    .bus_request_n(bus_request_n), .ad_lo_in(ad_w),
    .ad_lo_out(ad_lo_out), .ad_lo_oe(ad_lo_oe),
    .addr_hi_out(addr_hi_out), .addr_hi_oe(addr_hi_oe),
    .addr_strobe_n(as_n), .addr_strobe_oe(as_oe), .data_strobe_n(ds_n),
    .data_strobe_oe(ds_oe), .lower_block_strobe_n(ds2_n),
    .lower_block_strobe_oe(ds2_oe), .rw_out(rw_out), .rw_oe(rw_oe),
    .bus_ack_n(bus_ack_n));
  xmb_mem_model i_xmb_mem_model (.hclk(hclk), .as_w(as_w), .ds_w(ds_w),
    .ds2_w(ds2_w), .rw_w(rw_w), .ad_w(ad_w), .hi_w(hi_w),
    .ad_drv(ad_drv), .last_addr(last_addr), .last_rw(last_rw),
    .as_cnt(as_cnt), .ds_cnt(ds_cnt), .ds2_cnt(ds2_cnt));

  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_cnt(input int e, input int g);
    samples_checked++;
    if (g != e) begin
      fail_count++;
      $display("unexpected count at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // Strobe pulses expected on the main strobe for a write plus a read
  function automatic int ds_exp(input logic blk, input logic en);
    return (blk || !en) ? 2 : 0;
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic access(input logic [21:0] a, input logic wr,
                        input logic intl, input logic [7:0] d);
    ahb(1'b1, OFS_ADDR, {10'h0, a});
    ahb(1'b1, OFS_WDATA, {24'h0, d});
    ahb(1'b1, OFS_CMD, (32'(wr) << CMD_WRITE) | (32'(intl) << CMD_INTERNAL));
  endtask
  task automatic wait_idle();
    int n = 0;
    do begin
      ahb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 60);
    if (rd[STAT_BUSY] !== 1'b0) fail_count++;
  endtask
  task automatic ext_rw(input logic [21:0] a, input logic [7:0] d);
    int a0 = as_cnt;
    int d0 = ds_cnt;
    int l0 = ds2_cnt;
    access(a, 1'b1, 1'b0, d);
    wait_idle();
    chk_val({16'h0, a[15:0]}, {16'h0, last_addr});
    chk_val(32'h0, {31'h0, last_rw});
    access(a, 1'b0, 1'b0, 8'h00);
    wait_idle();
    chk_val(32'h1, {31'h0, last_rw});
    chk_val({24'h0, d}, {24'h0, rd[STAT_RD_LSB +: 8]});
    chk_cnt(a0 + 2, as_cnt);
    chk_cnt(d0 + ds_exp(a[21], lse), ds_cnt);
    chk_cnt(l0 + 2 - ds_exp(a[21], lse), ds2_cnt);
    chk_val(32'h1, {31'h0, as_w});
  endtask

  initial begin
    int a0;
    void'($urandom(32'haa52));
    repeat (2) @(posedge hclk);
    chk_val(32'h1, {31'h0, ds_w});
    chk_val(32'h0, {31'h0, as_oe});
    hresetn <= 1'b1;
    lse = 1'b1;
    ahb(1'b1, OFS_CTRL, BASE | (32'h1 << CTRL_LSE));
    ext_rw(22'h3fffff, 8'hff);
    ext_rw(22'h000000, 8'h00);
    repeat (10) ext_rw(22'($urandom), 8'($urandom));
    a0 = as_cnt + ds_cnt + ds2_cnt;
    access(22'h000123, 1'b1, 1'b1, 8'h77);
    wait_idle();
    chk_cnt(a0, as_cnt + ds_cnt + ds2_cnt);
    lse = 1'b0;
    ahb(1'b1, OFS_CTRL, BASE);
    ext_rw(22'h000155, 8'ha5);
    ahb(1'b1, OFS_CTRL, BASE | (32'h1 << CTRL_FLOAT));
    a0 = as_cnt;
    access(22'h200011, 1'b1, 1'b0, 8'h11);
    wait_idle();
    chk_cnt(a0, as_cnt);
    lse = 1'b1;
    ahb(1'b1, OFS_CTRL, BASE | (32'h1 << CTRL_LSE) | (32'h1 << CTRL_BUS_REQUEST_N_EN));
    ext_rw(22'h2000aa, 8'h3c);
    bus_request_n <= 1'b0;
    access(22'h2000aa, 1'b0, 1'b0, 8'h00);
    a0 = 0;
    while (bus_ack_n !== 1'b0 && a0 < 100) begin
      @(posedge hclk);
      a0++;
    end
    chk_val(32'h0, {29'h0, as_oe, ad_lo_oe, rw_oe});
    chk_val(32'h1, {31'h0, ds_w});
    bus_request_n <= 1'b1;
    wait_idle();
    chk_val(32'h3c, {24'h0, rd[STAT_RD_LSB +: 8]});
    // Second reset with the strap up: external mode with wait states
    romless_strap <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk_val(32'((1 << CTRL_EXT) | (1 << CTRL_WAIT)), rd);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk_val(32'h1 << STAT_STRAP, {29'h0, rd[2:0]});
    ahb(1'b1, OFS_CTRL, BASE | (32'h1 << CTRL_WAIT) | (32'h1 << CTRL_LSE));
    ext_rw(22'h0000c3, 8'h96);
    end_sim();
  end
endmodule // xmb_core_tb_top
